// ---- src/wdt_top.sv ----
// watchdog interval timer with password-protected register writes
`include "wdt_regs.svh"
`default_nettype none
module wdt_top
  import wdt_pkg::*;
#(
  parameter int HOLD_CYCLES = `WDT_RESET_HOLD_CYCLES
) (
  // clock, reset and standby
  input wire logic clk,
  input wire logic rst,
  input wire logic standby,
  // register bus
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic bus_word,
  input wire logic [15:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  output logic [7:0] bus_rdata,
  output logic bus_rvalid,
  // system control read port
  output logic ext_reset_source,
  // events
  output logic interval_irq,
  output logic nmi_req,
  output logic chip_reset_req,
  output logic reset_out_n
);
  //--------------------------------------------------------------
  // bus decode
  //--------------------------------------------------------------
  wdt_bus_req_s req;
  wdt_cs_s cs_reg;
  wdt_cs_s cs_next;
  wdt_state_e state_reg;
  logic [7:0] count_reg;
  logic [7:0] count_next;
  logic ovf_seen_reg;
  logic [9:0] hold_reg;
  logic tick;
  logic wr_word;
  logic wr_count;
  logic wr_cs;
  logic rd_cs;
  logic rd_count;
  logic inc;
  logic rollover;
  logic wd_reset;
  logic [7:0] cs_read;

  assign req = '{valid: bus_valid, write: bus_write, word: bus_word, addr: bus_addr, wdata: bus_wdata};
  assign wr_word = req.valid && req.write && req.word && (req.addr == `WDT_ADDR_WRITE);
  assign wr_count = wr_word && (req.wdata[15:8] == `WDT_PASS_COUNT);
  assign wr_cs = wr_word && (req.wdata[15:8] == `WDT_PASS_CS);
  assign rd_cs = req.valid && !req.write && (req.addr == `WDT_ADDR_CS);
  assign rd_count = req.valid && !req.write && (req.addr == `WDT_ADDR_COUNT);
  assign cs_read = {cs_reg.overflow_flag, cs_reg.timer_mode_sel, cs_reg.timer_run, 1'b1,
                    cs_reg.reset_action, cs_reg.clk_div_sel};

  //--------------------------------------------------------------
  // counter
  //--------------------------------------------------------------
  wdt_prescaler #(.WIDTH(12)) u_prescaler (
    .clk(clk),
    .rst(rst),
    .div_sel(cs_reg.clk_div_sel),
    .tick(tick)
  );

  assign inc = cs_reg.timer_run && tick && !wr_count;
  assign rollover = inc && (count_reg == 8'hFF);
  assign count_next = !cs_reg.timer_run ? `WDT_COUNT_RESET :
                      wr_count ? req.wdata[7:0] :
                      inc ? count_reg + 8'h01 : count_reg;
  assign wd_reset = rollover && cs_reg.timer_mode_sel && cs_reg.reset_action;

  //--------------------------------------------------------------
  // control/status next value
  //--------------------------------------------------------------
  always_comb begin
    cs_next = cs_reg;
    if (wr_cs) begin
      cs_next.timer_mode_sel = req.wdata[`WDT_BIT_MODE];
      cs_next.timer_run = req.wdata[`WDT_BIT_RUN];
      cs_next.reset_action = req.wdata[`WDT_BIT_ACT];
      cs_next.clk_div_sel = req.wdata[2:0];
      if (!req.wdata[`WDT_BIT_OVF] && ovf_seen_reg) begin
        cs_next.overflow_flag = 1'b0;
      end
    end
    // set wins over the write clear; the standby clear wins over both
    if (rollover) begin
      cs_next.overflow_flag = 1'b1;
    end
    if (standby) begin
      cs_next.overflow_flag = 1'b0;
      cs_next.timer_mode_sel = 1'b0;
      cs_next.timer_run = 1'b0;
      cs_next.reset_action = 1'b0;
    end
  end

  //--------------------------------------------------------------
  // registers
  //--------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_reg <= '0;
      count_reg <= `WDT_COUNT_RESET;
    end else begin
      cs_reg <= cs_next;
      count_reg <= standby ? `WDT_COUNT_RESET : count_next;
    end
  end

  // remembers that the flag was read while set
  always_ff @(posedge clk) begin
    if (rst || standby) begin
      ovf_seen_reg <= 1'b0;
    end else if (rd_cs && cs_reg.overflow_flag) begin
      ovf_seen_reg <= 1'b1;
    end else if (wr_cs || !cs_reg.overflow_flag) begin
      ovf_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_rdata <= 8'h00;
      bus_rvalid <= 1'b0;
    end else begin
      bus_rvalid <= rd_cs || rd_count;
      bus_rdata <= rd_cs ? cs_read : (rd_count ? count_reg : 8'h00);
    end
  end

  //--------------------------------------------------------------
  // overflow actions
  //--------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      interval_irq <= 1'b0;
      nmi_req <= 1'b0;
    end else begin
      interval_irq <= rollover && !cs_reg.timer_mode_sel;
      nmi_req <= rollover && cs_reg.timer_mode_sel && !cs_reg.reset_action;
    end
  end

  // reset hold is cleared by the same rst input as the rest of the timer; it has no reset input of its own
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= WDT_ST_IDLE;
      hold_reg <= 10'h000;
      chip_reset_req <= 1'b0;
      reset_out_n <= 1'b1;
      ext_reset_source <= 1'b1;
    end else begin
      case (state_reg)
        WDT_ST_IDLE: begin
          if (wd_reset) begin
            state_reg <= WDT_ST_RESET_HOLD;
            hold_reg <= 10'(HOLD_CYCLES - 1);
            chip_reset_req <= 1'b1;
            reset_out_n <= 1'b0;
            ext_reset_source <= 1'b0;
          end
        end
        WDT_ST_RESET_HOLD: begin
          if (hold_reg == 10'h000) begin
            state_reg <= WDT_ST_IDLE;
            chip_reset_req <= 1'b0;
            reset_out_n <= 1'b1;
          end else begin
            hold_reg <= hold_reg - 10'h001;
          end
        end
        default: begin
          state_reg <= WDT_ST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- shared/wdt_regs.svh ----
// register map, field positions, reset values and timing counts of the watchdog interval timer
`ifndef WDT_REGS_SVH
`define WDT_REGS_SVH

`define WDT_ADDR_WRITE 16'hFFA8
`define WDT_ADDR_CS 16'hFFA8
`define WDT_ADDR_COUNT 16'hFFA9
`define WDT_PASS_COUNT 8'h5A
`define WDT_PASS_CS 8'hA5
`define WDT_CS_RESET 8'h10
`define WDT_COUNT_RESET 8'h00
`define WDT_BIT_OVF 7
`define WDT_BIT_MODE 6
`define WDT_BIT_RUN 5
`define WDT_BIT_RSVD 4
`define WDT_BIT_ACT 3
`define WDT_SYSTEM_CONTROL_BIT_EXT_RESET_SOURCE 3
`define WDT_RESET_HOLD_CYCLES 518

`endif

// ---- shared/wdt_pkg.sv ----
// types shared by the watchdog interval timer
`default_nettype none
package wdt_pkg;
  typedef struct packed {
    logic overflow_flag;
    logic timer_mode_sel;
    logic timer_run;
    logic reset_action;
    logic [2:0] clk_div_sel;
  } wdt_cs_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic word;
    logic [15:0] addr;
    logic [15:0] wdata;
  } wdt_bus_req_s;

  typedef enum logic [1:0] {
    WDT_ST_IDLE = 2'b00,
    WDT_ST_RESET_HOLD = 2'b01
  } wdt_state_e;
endpackage
`default_nettype wire

// ---- src/wdt_prescaler.sv ----
// free prescaler giving one-cycle count pulses at a selected division
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int WIDTH = 12
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic [2:0] div_sel,
  // pulse out
  output logic tick
);
  logic [WIDTH-1:0] div_reg;
  logic [WIDTH-1:0] div_next;
  logic [WIDTH-1:0] div_mask;
  assign div_mask = (div_sel == 3'h0) ? WIDTH'(12'h001) :
                    (div_sel == 3'h1) ? WIDTH'(12'h01F) :
                    (div_sel == 3'h2) ? WIDTH'(12'h03F) :
                    (div_sel == 3'h3) ? WIDTH'(12'h07F) :
                    (div_sel == 3'h4) ? WIDTH'(12'h0FF) :
                    (div_sel == 3'h5) ? WIDTH'(12'h1FF) :
                    (div_sel == 3'h6) ? WIDTH'(12'h7FF) : WIDTH'(12'hFFF);
  assign div_next = div_reg + WIDTH'(1);

  always_ff @(posedge clk) begin
    if (rst) begin
      div_reg <= '0;
      tick <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick <= ((div_reg & div_mask) == div_mask);
    end
  end
endmodule
`default_nettype wire

// ---- dv/wdt_top_asserts.sv ----
// port-level assertion checker for the watchdog interval timer
`default_nettype none
module wdt_top_asserts
  import wdt_pkg::*;
#(
  parameter int HOLD_CYCLES = 518
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register bus
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_rdata,
  input wire logic bus_rvalid,
  // events
  input wire logic ext_reset_source,
  input wire logic interval_irq,
  input wire logic nmi_req,
  input wire logic chip_reset_req,
  input wire logic reset_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic [10:0] hold_reg;
  wire logic rd_hit = bus_valid && !bus_write && bus_addr[15:1] == 15'h7FD4;
  wire logic rd_miss = bus_valid && !bus_write && bus_addr[15:1] != 15'h7FD4;
  always_ff @(posedge clk) hold_reg <= chip_reset_req ? hold_reg + 11'h001 : 11'h000;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_rv; rd_hit |=> bus_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_norv; rd_miss |=> !bus_rvalid; endproperty
  a_norv: assert property (p_norv) else $error("unmapped read answered");
  property p_rsvd; bus_rvalid && $past(bus_addr) == 16'hFFA8 |-> bus_rdata[4]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("bit four read low");
  property p_rst; $fell(rst) |-> reset_out_n && !chip_reset_req && ext_reset_source; endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_ro; reset_out_n != chip_reset_req; endproperty
  a_ro: assert property (p_ro) else $error("reset out disagrees");
  property p_cr; $rose(chip_reset_req) |-> !ext_reset_source; endproperty
  a_cr: assert property (p_cr) else $error("source flag not cleared");
  property p_hold; $fell(chip_reset_req) |-> hold_reg == HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("reset hold length wrong");
  property p_irq; interval_irq |-> !nmi_req ##1 !interval_irq; endproperty
  a_irq: assert property (p_irq) else $error("interval pulse wrong");
  property p_nmi; nmi_req |-> !chip_reset_req && !interval_irq ##1 !nmi_req; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi pulse wrong");
endmodule
bind wdt_top wdt_top_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) u_chk (.clk, .rst, .bus_valid, .bus_write, .bus_addr,
  .bus_rdata, .bus_rvalid, .ext_reset_source, .interval_irq, .nmi_req, .chip_reset_req, .reset_out_n);
`default_nettype wire

// ---- dv/wdt_cpu_model.sv ----
// cpu-side bus master issuing single reads and writes of either width
`default_nettype none
module wdt_cpu_model
  import wdt_pkg::*;
(
  // clock
  input wire logic clk,
  // bus request
  output var wdt_bus_req_s req
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req = '0;
  // one access held over one taken edge, then released
  task automatic acc(input logic wr, input logic wd, input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    req = '{1'b1, wr, wd, a, d};
    @(negedge clk);
    req = '{1'b0, 1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the watchdog interval timer
`default_nettype none
module tb;
  import wdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic standby = 1'b0;
  wdt_bus_req_s req;
  logic [7:0] bus_rdata, v;
  logic bus_rvalid, ext_reset_source, interval_irq, nmi_req, chip_reset_req, reset_out_n;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32;
  logic [7:0] exp_q[$];
  wire logic [2:0] ev = {chip_reset_req, nmi_req, interval_irq};
  always #4 clk = ~clk;
  wdt_cpu_model cpu (.clk(clk), .req(req));
  wdt_top #(.HOLD_CYCLES(8)) uut (.clk(clk), .rst(rst), .standby(standby), .bus_valid(req.valid),
    .bus_write(req.write), .bus_word(req.word), .bus_addr(req.addr), .bus_wdata(req.wdata),
    .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .ext_reset_source(ext_reset_source),
    .interval_irq(interval_irq), .nmi_req(nmi_req), .chip_reset_req(chip_reset_req), .reset_out_n(reset_out_n));
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] d);
    cpu.acc(1'b1, 1'b1, 16'hFFA8, d);
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    cpu.acc(1'b0, 1'b0, a, 16'h0000);
    @(negedge clk);
  endtask
  task automatic wait_hi(input int k);
    for (int i = 0; i < 2000 && ev[k] !== 1'b1; i++) @(negedge clk);
  endtask
  always @(negedge clk) begin
    if (bus_rvalid === 1'b1) chk(bus_rdata, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    chk(ext_reset_source, 1'b1);
    rd(16'hFFA8, 8'h10);
    rd(16'hFFA9, 8'h00);
    cpu.acc(1'b1, 1'b0, 16'hFFA8, 16'hA5FF);
    wr(16'h33FF);
    rd(16'hFFA8, 8'h10);
    wr(16'hA520);
    wr(16'h5AFD);
    wait_hi(0);
    chk(interval_irq, 1'b1);
    rd(16'hFFA8, 8'hB0);
    wr(16'hA520);
    rd(16'hFFA8, 8'h30);
    wr(16'hA580);
    rd(16'hFFA8, 8'h10);
    rd(16'hFFA9, 8'h00);
    wr(16'hA527);
    repeat (3) begin
      v = 8'($random(seed));
      wr({8'h5A, v});
      rd(16'hFFA9, v);
    end
    wr(16'hA500);
    wr(16'hA560);
    wr(16'h5AFE);
    wait_hi(1);
    chk(nmi_req, 1'b1);
    wr(16'hA500);
    wr(16'hA56B);
    wr(16'h5AFE);
    wait_hi(2);
    chk({ext_reset_source, reset_out_n}, 2'b00);
    repeat (12) @(negedge clk);
    standby = 1'b1;
    @(negedge clk);
    standby = 1'b0;
    rd(16'hFFA8, 8'h13);
    rd(16'hFFA9, 8'h00);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk(ext_reset_source, 1'b1);
    rd(16'hFFA8, 8'h10);
    tally_and_finish();
  end
endmodule
`default_nettype wire
